// ---- rtl/mce_command_executor.sv ----
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module mce_command_executor #(
    parameter int DEV_NUM = 16,
    parameter int COL_NUM = 16,
    parameter logic [4:0] ID_BITS = 5'd15,
    parameter bit SYSTEM_ERROR_SUPPORT_BIT = 1'b1
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Register bus, write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Register bus, read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Translation entry writes
    output logic             teWrite,
    output logic [47:0]      teAddr,
    output logic [31:0]      teOutId,
    output logic [9:0]       teBellId,
    output logic [15:0]      teCollection,
    output logic [3:0]       teAttr,
    // Redistributor move-all and cache invalidate
    output logic             moveStb,
    output logic [31:0]      moveFrom,
    output logic [31:0]      moveTo,
    output logic             invStb,
    output logic [31:0]      invDevice,
    output logic             sysErr,
    // Incoming translation requests
    input  wire logic        reqValid,
    input  wire logic [31:0] reqDevice,
    input  wire logic [31:0] reqEvent,
    output logic             reqHit,
    output logic             reqDrop,
    output logic [47:0]      reqEntryAddr
);

    localparam int DW = $clog2(DEV_NUM);

    // Bus state
    logic        awRdy_q, wRdy_q, bValid_q, arRdy_q, rValid_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q, rData_q;
    logic [3:0]  wStrb_q;
    logic [1:0]  bResp_q, rResp_q;
    // Software registers
    logic [31:0] pkt_q [mce_pkg::PKT_WORDS];
    logic [3:0]  attr_q;
    // Command state
    mce_pkg::mce_state_t state_q;
    logic [31:0] cmd_q [mce_pkg::PKT_WORDS];
    logic [3:0]  err_q, errD, lastErr_q;
    logic [15:0] rptr_q;
    // Device table
    logic        dtValid_q [DEV_NUM];
    logic [39:0] dtBase_q  [DEV_NUM];
    logic [4:0]  dtSize_q  [DEV_NUM];
    // Output flops
    logic        teWrite_q, moveStb_q, invStb_q, sysErr_q, reqHit_q, reqDrop_q;
    logic [47:0] teAddr_q, reqAddr_q;
    logic [31:0] teOutId_q, moveFrom_q, moveTo_q, invDev_q;
    logic [9:0]  teBell_q;
    logic [15:0] teCol_q;
    logic [3:0]  teAttr_q;

    // Event number must fit in size+1 bits
    function automatic logic evtOor(input logic [31:0] evt, input logic [4:0] size);
        logic [5:0] nb;
        nb = {1'b0, size} + 6'd1;
        return (nb < 6'd32) && ((evt >> nb) != 32'h0);
    endfunction

    // Entry address: table base with zero low bits plus scaled event
    function automatic logic [47:0] entryAddr(input logic [39:0] base,
                                              input logic [31:0] evt);
        return {base, {mce_pkg::TT_ALIGN{1'b0}}} + ({16'h0, evt} << mce_pkg::TE_SHIFT);
    endfunction

    function automatic logic devOor(input logic [31:0] dev);
        return dev >= 32'(DEV_NUM);
    endfunction

    // Command fields, located by doubleword
    logic [7:0]  cOp;
    logic [31:0] cDev, cEvt, cPid, cRd1, cRd2;
    logic [15:0] cCol;
    logic [4:0]  cSize;
    logic        cValid, mapped, isMapEvt;
    logic [39:0] cTtAddr;
    logic [DW-1:0] cIdx;
    assign cOp     = cmd_q[0][7:0];
    assign cDev    = cmd_q[1];
    assign cEvt    = cmd_q[2];
    assign cPid    = (cOp == mce_pkg::OP_MAP_EVT_I) ? cmd_q[2] : cmd_q[3];
    assign cSize   = cmd_q[2][4:0];
    assign cCol    = cmd_q[4][15:0];
    assign cValid  = cmd_q[5][31];
    assign cTtAddr = {cmd_q[5][15:0], cmd_q[4][31:8]};
    assign cRd1    = {cmd_q[5][15:0], cmd_q[4][31:16]};
    assign cRd2    = {cmd_q[7][15:0], cmd_q[6][31:16]};
    assign cIdx    = cDev[DW-1:0];
    assign mapped  = dtValid_q[cIdx];
    assign isMapEvt = (cOp == mce_pkg::OP_MAP_EVT_I) || (cOp == mce_pkg::OP_MAP_EVT_X);

    // Bus write strobe: address and data both held, no response pending
    logic wrEn, goReq;
    assign wrEn  = !awRdy_q && !wRdy_q && !bValid_q;
    assign goReq = wrEn && (awAddr_q == mce_pkg::OFF_CTRL) && wStrb_q[0]
                   && wData_q[mce_pkg::CTRL_GO];

    function automatic logic addrHit(input logic [7:0] a);
        return (a < mce_pkg::OFF_CTRL) || (a == mce_pkg::OFF_CTRL) || (a == mce_pkg::OFF_TYPE)
            || (a == mce_pkg::OFF_ATTR) || (a == mce_pkg::OFF_STAT);
    endfunction

    // Write address and data taken in either order, released by the response
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            awRdy_q  <= 1'b1;
            wRdy_q   <= 1'b1;
            bValid_q <= 1'b0;
            bResp_q  <= mce_pkg::RESP_OKAY;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
        end else begin
            if (awRdy_q && s_axi_awvalid) begin
                awRdy_q  <= 1'b0;
                awAddr_q <= s_axi_awaddr;
            end
            if (wRdy_q && s_axi_wvalid) begin
                wRdy_q  <= 1'b0;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrEn) begin
                bValid_q <= 1'b1;
                bResp_q  <= addrHit(awAddr_q) ? mce_pkg::RESP_OKAY : mce_pkg::RESP_SLVERR;
            end
            if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
                awRdy_q  <= 1'b1;
                wRdy_q   <= 1'b1;
            end
        end
    end

    // Packet and attribute registers, byte lanes honoured
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < mce_pkg::PKT_WORDS; i++) begin
                pkt_q[i] <= 32'h0;
            end
            attr_q <= mce_pkg::ATTR_RST;
        end else if (wrEn) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb_q[b] && (awAddr_q < mce_pkg::OFF_CTRL)) begin
                    pkt_q[awAddr_q[4:2]][8*b +: 8] <= wData_q[8*b +: 8];
                end
            end
            if (awAddr_q == mce_pkg::OFF_ATTR && wStrb_q[0]) begin
                attr_q <= wData_q[mce_pkg::ATTR_W-1:0];
            end
        end
    end

    // Read channel; one read in flight
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            arRdy_q  <= 1'b1;
            rValid_q <= 1'b0;
            rData_q  <= 32'h0;
            rResp_q  <= mce_pkg::RESP_OKAY;
        end else if (arRdy_q && s_axi_arvalid) begin
            arRdy_q  <= 1'b0;
            rValid_q <= 1'b1;
            rResp_q  <= addrHit(s_axi_araddr) ? mce_pkg::RESP_OKAY : mce_pkg::RESP_SLVERR;
            rData_q  <= 32'h0;
            if (s_axi_araddr < mce_pkg::OFF_CTRL) begin
                rData_q <= pkt_q[s_axi_araddr[4:2]];
            end else if (s_axi_araddr == mce_pkg::OFF_TYPE) begin
                rData_q <= {23'h0, SYSTEM_ERROR_SUPPORT_BIT, 3'h0, ID_BITS};
            end else if (s_axi_araddr == mce_pkg::OFF_ATTR) begin
                rData_q <= {28'h0, attr_q};
            end else if (s_axi_araddr == mce_pkg::OFF_STAT) begin
                rData_q <= {rptr_q, 8'h0, lastErr_q, 3'h0, state_q != mce_pkg::ST_IDLE};
            end
        end else if (rValid_q && s_axi_rready) begin
            rValid_q <= 1'b0;
            arRdy_q  <= 1'b1;
        end
    end

    // Check order follows the command's own list; first failure wins
    always_comb begin
        errD = mce_pkg::ERR_NONE;
        if (cOp == mce_pkg::OP_MAP_DEV) begin
            if (devOor(cDev)) begin
                errD = mce_pkg::ERR_DEV_OOR;
            end else if (cValid && cSize > ID_BITS) begin
                errD = mce_pkg::ERR_SIZE_OOR;
            end
        end else if (isMapEvt) begin
            if (devOor(cDev)) begin
                errD = mce_pkg::ERR_DEV_OOR;
            end else if (32'(cCol) >= 32'(COL_NUM)) begin
                errD = mce_pkg::ERR_COL_OOR;
            end else if (!mapped) begin
                errD = mce_pkg::ERR_UNMAPPED;
            end else if (evtOor(cEvt, dtSize_q[cIdx])) begin
                errD = mce_pkg::ERR_EVT_OOR;
            end else if (cPid < mce_pkg::MSG_INT_MIN) begin
                errD = mce_pkg::ERR_PID_OOR;
            end
        end else if (cOp != mce_pkg::OP_MOVE_ALL) begin
            errD = mce_pkg::ERR_UNKNOWN;
        end
    end

    // Command sequencer; packets written while busy wait for the next go
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= mce_pkg::ST_IDLE;
            err_q     <= mce_pkg::ERR_NONE;
            lastErr_q <= mce_pkg::ERR_NONE;
            rptr_q    <= 16'h0;
            for (int i = 0; i < mce_pkg::PKT_WORDS; i++) begin
                cmd_q[i] <= 32'h0;
            end
        end else begin
            case (state_q)
                mce_pkg::ST_IDLE: begin
                    if (goReq) begin
                        cmd_q   <= pkt_q;
                        state_q <= mce_pkg::ST_CHECK;
                    end
                end
                mce_pkg::ST_CHECK: begin
                    err_q   <= errD;
                    state_q <= mce_pkg::ST_APPLY;
                end
                mce_pkg::ST_APPLY: begin
                    lastErr_q <= err_q;
                    rptr_q    <= rptr_q + 16'h1;
                    state_q   <= mce_pkg::ST_IDLE;
                end
                default: state_q <= mce_pkg::ST_IDLE;
            endcase
        end
    end

    // Device table update only on a clean map-device
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEV_NUM; i++) begin
                dtValid_q[i] <= 1'b0;
                dtBase_q[i]  <= 40'h0;
                dtSize_q[i]  <= 5'h0;
            end
        end else if (state_q == mce_pkg::ST_APPLY && err_q == mce_pkg::ERR_NONE
                     && cOp == mce_pkg::OP_MAP_DEV) begin
            dtValid_q[cIdx] <= cValid;
            if (cValid) begin
                dtBase_q[cIdx] <= cTtAddr;
                dtSize_q[cIdx] <= cSize;
            end
        end
    end

    // Command side effects, all one-cycle pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            teWrite_q  <= 1'b0;
            teAddr_q   <= 48'h0;
            teOutId_q  <= 32'h0;
            teBell_q   <= 10'h0;
            teCol_q    <= 16'h0;
            teAttr_q   <= mce_pkg::ATTR_RST;
            moveStb_q  <= 1'b0;
            moveFrom_q <= 32'h0;
            moveTo_q   <= 32'h0;
            invStb_q   <= 1'b0;
            invDev_q   <= 32'h0;
            sysErr_q   <= 1'b0;
        end else begin
            teWrite_q <= 1'b0;
            moveStb_q <= 1'b0;
            invStb_q  <= 1'b0;
            sysErr_q  <= 1'b0;
            if (state_q == mce_pkg::ST_APPLY) begin
                if (err_q != mce_pkg::ERR_NONE) begin
                    sysErr_q <= SYSTEM_ERROR_SUPPORT_BIT && (err_q != mce_pkg::ERR_UNKNOWN);
                end else if (isMapEvt) begin
                    teWrite_q <= 1'b1;
                    teAddr_q  <= entryAddr(dtBase_q[cIdx], cEvt);
                    teOutId_q <= cPid;
                    teBell_q  <= mce_pkg::SPURIOUS_ID;
                    teCol_q   <= cCol;
                    teAttr_q  <= attr_q;
                end else if (cOp == mce_pkg::OP_MOVE_ALL) begin
                    moveStb_q  <= cRd1 != cRd2;
                    moveFrom_q <= cRd1;
                    moveTo_q   <= cRd2;
                end else if (mapped) begin
                    invStb_q <= 1'b1;
                    invDev_q <= cDev;
                end
            end
        end
    end

    // Translation requests: unmapped or out-of-range ones are dropped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reqHit_q  <= 1'b0;
            reqDrop_q <= 1'b0;
            reqAddr_q <= 48'h0;
        end else begin
            reqHit_q  <= 1'b0;
            reqDrop_q <= 1'b0;
            if (reqValid) begin
                if (devOor(reqDevice) || !dtValid_q[reqDevice[DW-1:0]]
                    || evtOor(reqEvent, dtSize_q[reqDevice[DW-1:0]])) begin
                    reqDrop_q <= 1'b1;
                end else begin
                    reqHit_q  <= 1'b1;
                    reqAddr_q <= entryAddr(dtBase_q[reqDevice[DW-1:0]], reqEvent);
                end
            end
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awRdy_q;
    assign s_axi_wready  = wRdy_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arRdy_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign teWrite       = teWrite_q;
    assign teAddr        = teAddr_q;
    assign teOutId       = teOutId_q;
    assign teBellId      = teBell_q;
    assign teCollection  = teCol_q;
    assign teAttr        = teAttr_q;
    assign moveStb       = moveStb_q;
    assign moveFrom      = moveFrom_q;
    assign moveTo        = moveTo_q;
    assign invStb        = invStb_q;
    assign invDevice     = invDev_q;
    assign sysErr        = sysErr_q;
    assign reqHit        = reqHit_q;
    assign reqDrop       = reqDrop_q;
    assign reqEntryAddr  = reqAddr_q;

endmodule

// ---- rtl/mce_pkg.sv ----
package mce_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_PKT   = 8'h00;  // Eight words, command doublewords 0..3
    localparam logic [7:0] OFF_CTRL  = 8'h20;
    localparam logic [7:0] OFF_TYPE  = 8'h24;
    localparam logic [7:0] OFF_ATTR  = 8'h28;
    localparam logic [7:0] OFF_STAT  = 8'h2c;
    localparam int         PKT_WORDS = 8;

    // Field positions
    localparam int CTRL_GO       = 0;
    localparam int TYPE_SYSTEM_ERROR_SUPPORT_BIT     = 8;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_ERR_LSB  = 4;
    localparam int STAT_RPTR_LSB = 16;
    localparam int ATTR_W        = 4;
    localparam logic [3:0] ATTR_RST = 4'h0;

    // Command opcodes, low byte of doubleword 0
    localparam logic [7:0] OP_MAP_DEV   = 8'h08;
    localparam logic [7:0] OP_MAP_EVT_X = 8'h0a;
    localparam logic [7:0] OP_MAP_EVT_I = 8'h0b;
    localparam logic [7:0] OP_MOVE_ALL  = 8'h0e;

    // Outcome codes shown in the status register
    localparam logic [3:0] ERR_NONE     = 4'h0;
    localparam logic [3:0] ERR_DEV_OOR  = 4'h1;
    localparam logic [3:0] ERR_SIZE_OOR = 4'h2;
    localparam logic [3:0] ERR_COL_OOR  = 4'h3;
    localparam logic [3:0] ERR_UNMAPPED = 4'h4;
    localparam logic [3:0] ERR_EVT_OOR  = 4'h5;
    localparam logic [3:0] ERR_PID_OOR  = 4'h6;
    localparam logic [3:0] ERR_UNKNOWN  = 4'h7;

    // Interrupt number constants
    localparam logic [31:0] MSG_INT_MIN = 32'h00002000;
    localparam logic [9:0]  SPURIOUS_ID = 10'h3ff;
    localparam int          TT_ALIGN    = 8;   // 256-byte aligned tables
    localparam int          TE_SHIFT    = 3;   // 8-byte translation entries

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_APPLY = 3'b100
    } mce_state_t;

endpackage

// ---- tb/mce_command_checker.sv ----
`timescale 1ns/1ns
module mce_command_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // Register bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // Command effects
    input wire logic        teWrite,
    input wire logic [31:0] teOutId,
    input wire logic [9:0]  teBellId,
    input wire logic        moveStb,
    input wire logic [31:0] moveFrom,
    input wire logic [31:0] moveTo,
    input wire logic        invStb,
    input wire logic        sysErr,
    // Translation requests
    input wire logic        reqValid,
    input wire logic        reqHit,
    input wire logic        reqDrop,
    input wire logic [47:0] reqEntryAddr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Write taken on both channels at once, then the answer
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Effects only follow a write response seen two or three cycles earlier, never out of nowhere
    sequence goDone;
        $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endsequence

    a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid) else $error("late bvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late rvalid");
    a_bell_spurious: assert property (teWrite |-> teBellId == mce_pkg::SPURIOUS_ID)
        else $error("doorbell not spurious");
    a_outid_range: assert property (teWrite |-> teOutId >= mce_pkg::MSG_INT_MIN)
        else $error("output id too small");
    a_err_alone: assert property (sysErr |-> !(teWrite || invStb || moveStb))
        else $error("table touched on error");
    a_effect_cause: assert property ((teWrite || invStb || moveStb || sysErr) |-> goDone)
        else $error("effect without command");
    a_req_answer: assert property (reqValid |=> reqHit != reqDrop)
        else $error("request unanswered");
    a_req_cause: assert property ((reqHit || reqDrop) |-> $past(reqValid))
        else $error("answer without request");
    a_move_distinct: assert property (moveStb |-> moveFrom != moveTo)
        else $error("move to same target");
    a_entry_grain: assert property (reqHit |-> reqEntryAddr[2:0] == 3'h0)
        else $error("entry address misaligned");
    a_pulse_single: assert property (teWrite |=> !teWrite)
        else $error("entry write stretched");
endmodule

// ---- tb/mce_dev_model.sv ----
`timescale 1ns/1ns
module mce_dev_model (
    // Clock
    input wire logic        ref_clk,
    // Bench request
    input wire logic        fire,
    input wire logic [31:0] fireDev,
    input wire logic [31:0] fireEvt,
    // Translation request lines
    output logic            reqValid,
    output logic [31:0]     reqDevice,
    output logic [31:0]     reqEvent
);
    initial begin
        reqValid = 1'b0;
        reqDevice = 32'h0;
        reqEvent = 32'h0;
    end
    // Idle lines toggle so a stale value never passes for a request
    always @(posedge ref_clk) begin
        reqValid <= fire;
        reqDevice <= fire ? fireDev : ~reqDevice;
        reqEvent <= fire ? fireEvt : ~reqEvent;
    end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
    // Design inputs
    logic ref_clk = 0, reset_n = 0, fire = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, fireDev = 0, fireEvt = 0, reqDevice, reqEvent, rd;
    logic [3:0] s_axi_wstrb = 0, teAttr;
    // Design outputs
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reqValid;
    logic teWrite, moveStb, invStb, sysErr, reqHit, reqDrop;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, teOutId, moveFrom, moveTo, invDevice;
    logic [47:0] teAddr, reqEntryAddr;
    logic [9:0] teBellId;
    logic [15:0] teCollection;
    // Reference model state
    int err_count = 0, compares = 0, rp = 0, nTe, nInv, nMove, nErr, nReq;
    int dv[16], ds[16], eCol, eHit, eErr;
    longint db[16], eAddr, eOut, eDev, eFrom, eTo;
    integer seed = 32'hbfba3b22;

    mce_command_executor #(.DEV_NUM(16), .COL_NUM(16), .ID_BITS(5'd15), .SYSTEM_ERROR_SUPPORT_BIT(1'b1)) DUT (.*);
    mce_dev_model u_dev (.*);

    always #10 ref_clk = ~ref_clk;

    task automatic check(string nm, logic [63:0] e, logic [63:0] g);
        compares++;
        if (e !== g) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task summarize;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic axw(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task automatic axr(logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // Predict from the packet, run it, then compare status and pulse counts
    task automatic cmd(logic [31:0] p[8]);
        longint dev, ev, pid, col, ad;
        int op, sz;
        op = p[0][7:0];
        dev = p[1];
        ev = p[2];
        sz = p[2][4:0];
        pid = p[3];
        col = p[4][15:0];
        ad = {p[5][15:0], p[4][31:8]};
        eErr = 0;
        eDev = dev;
        if (op == 8'h08) begin
            if (dev >= 16) eErr = 1;
            else if (p[5][31] && sz > 15) eErr = 2;
            else begin
                nInv = -dv[dev];
                dv[dev] = p[5][31];
                db[dev] = ad << 8;
                ds[dev] = sz;
            end
        end else if (op == 8'h0a || op == 8'h0b) begin
            if (op == 8'h0b) pid = ev;
            if (dev >= 16) eErr = 1;
            else if (col >= 16) eErr = 3;
            else if (!dv[dev]) eErr = 4;
            else if (ev >= (longint'(1) << (ds[dev] + 1))) eErr = 5;
            else if (pid < 'h2000) eErr = 6;
            else begin
                nTe = -1;
                eAddr = db[dev] + ev * 8;
                eOut = pid;
                eCol = col;
            end
        end else if (op == 8'h0e) begin
            eFrom = {p[5][15:0], p[4][31:16]};
            eTo = {p[7][15:0], p[6][31:16]};
            nMove = -(eFrom != eTo);
        end else eErr = 7;
        nErr = -(eErr != 0 && eErr != 7);
        rp++;
        for (int i = 0; i < 8; i++) axw(8'(i * 4), p[i]);
        axw(mce_pkg::OFF_CTRL, 32'h1);
        do axr(mce_pkg::OFF_STAT); while (rd[0]);
        check("last error", eErr, rd[7:4]);
        check("read pointer", rp, rd[31:16]);
        check("pulse balance", 0, nTe | nInv | nMove | nErr);
        {nTe, nInv, nMove, nErr} = '0;
    endtask

    task automatic req(logic [31:0] dev, logic [31:0] ev);
        eHit = dev < 16 && dv[dev[3:0]];
        eAddr = db[dev[3:0]] + ev * 8;
        nReq = -1;
        @(posedge ref_clk);
        fire <= 1;
        fireDev <= dev;
        fireEvt <= ev;
        @(posedge ref_clk);
        fire <= 0;
        repeat (4) @(posedge ref_clk);
        check("request answers", 0, nReq);
    endtask

    // Each pulse cancels one expected count; fields compared as they pass
    always @(posedge ref_clk) begin
        if (teWrite) begin
            nTe++;
            check("teAddr", eAddr, teAddr);
            check("teOutId", eOut, teOutId);
            check("teCollection", eCol, teCollection);
            check("teAttr", 5, teAttr);
        end
        if (invStb) begin
            nInv++;
            check("invDevice", eDev, invDevice);
        end
        if (moveStb) begin
            nMove++;
            check("moves", {eFrom[31:0], eTo[31:0]}, {moveFrom, moveTo});
        end
        if (sysErr) nErr++;
        if (reqHit || reqDrop) begin
            nReq++;
            check("reqHit", eHit, reqHit);
            if (reqHit) check("reqEntryAddr", eAddr, reqEntryAddr);
        end
    end

    initial begin
        #1_000_000;
        err_count++;
        summarize;
    end

    initial begin
        logic [31:0] r;
        {nTe, nInv, nMove, nErr, nReq} = '0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1;
        axr(mce_pkg::OFF_TYPE);
        check("type", 32'h10f, rd);
        axr(mce_pkg::OFF_STAT);
        check("status", 0, rd);
        axr(8'h30);
        check("unmapped", {mce_pkg::RESP_SLVERR, 32'h0}, {resp, rd});
        axw(mce_pkg::OFF_ATTR, 32'h5);
        check("write response", mce_pkg::RESP_OKAY, resp);
        axw(8'h30, 32'h1);
        check("bad write response", mce_pkg::RESP_SLVERR, resp);
        axr(mce_pkg::OFF_ATTR);
        check("attr", 5, rd);
        cmd('{8, 3, 14, 0, 32'h00abcd00, 32'h80000012, 0, 0});
        cmd('{8, 16, 4, 0, 0, 32'h80000000, 0, 0});
        cmd('{8, 4, 16, 0, 0, 32'h80000000, 0, 0});
        cmd('{8, 4, 15, 0, 32'h00001100, 32'h80000000, 0, 0});
        cmd('{11, 16, 'h2000, 0, 1, 0, 0, 0});
        cmd('{11, 3, 'h2000, 0, 16, 0, 0, 0});
        cmd('{11, 5, 'h2000, 0, 1, 0, 0, 0});
        cmd('{11, 3, 'h8000, 0, 1, 0, 0, 0});
        cmd('{11, 3, 'h1fff, 0, 1, 0, 0, 0});
        cmd('{10, 3, 'h100, 'h1fff, 2, 0, 0, 0});
        cmd('{10, 5, 'h100, 'h2000, 2, 0, 0, 0});
        cmd('{11, 3, 'h2000, 0, 15, 0, 0, 0});
        cmd('{11, 4, 'hffff, 0, 0, 0, 0, 0});
        // Distinct events per device keep away from double mapping
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            cmd('{10, 4, 'h100 + i, 'h2000 + r[31:16], r[3:0], 0, 0, 0});
        end
        req(3, 'h2000);
        req(5, 'h2000);
        // No interrupt left aimed at the source redistributor
        cmd('{14, 0, 0, 0, 32'h12340000, 32'h00000056, 32'h9abc0000, 32'h00000078});
        cmd('{14, 0, 0, 0, 32'h12340000, 32'h00000056, 32'h12340000, 32'h00000056});
        cmd('{5, 0, 0, 0, 0, 0, 0, 0});
        // Unmap first, check the device stays quiet, then remap to a fresh table
        cmd('{8, 3, 9, 0, 32'h00ffff00, 32'h00000000, 0, 0});
        req(3, 'h2000);
        cmd('{11, 3, 'h2000, 0, 1, 0, 0, 0});
        cmd('{8, 3, 14, 0, 32'h00555500, 32'h80000000, 0, 0});
        cmd('{8, 4, 14, 0, 32'h00777700, 32'h80000000, 0, 0});
        req(3, 'h2010);
        summarize;
    end
endmodule

bind mce_command_executor mce_command_checker u_chk (.*);
